// ==== design/mssis_pkg.sv ====
// package: constants for the motor speed sensor input stage
package mssis_pkg;
	// tacho edge select encodings
	localparam logic [1:0] TES_OFF = 2'h0; // position / sensorless
	localparam logic [1:0] TES_RISE = 2'h1;
	localparam logic [1:0] TES_FALL = 2'h2;
	localparam logic [1:0] TES_BOTH = 2'h3;
	// input select encodings
	localparam logic [1:0] IS_PIN_A = 2'h0;
	localparam logic [1:0] IS_PIN_B = 2'h1;
	localparam logic [1:0] IS_PIN_C = 2'h2;
	localparam logic [1:0] IS_ENCODER = 2'h3;
	// reset values
	localparam logic [1:0] INPUT_SELECT_RST = 2'h0;
	localparam logic [2:0] PINS_RST = 3'h0;
	// pin bit positions within the three-bit groups
	localparam int PIN_A = 0;
	localparam int PIN_B = 1;
	localparam int PIN_C = 2;
	localparam int NUM_PINS = 3;
	// input stage modes
	typedef enum logic [2:0] {
		MSSIS_SENSORLESS,
		MSSIS_POSITION,
		MSSIS_TACHO,
		MSSIS_ENCODER,
		MSSIS_ALL_GPIO,
		MSSIS_COMP_ONLY
	} mssis_mode_t;
endpackage

// ==== design/mssis_sync.sv ====
// file: two-stage synchroniser with edge pulses for the sensor pins
`timescale 1ns/1ps
module mssis_sync (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic [2:0] pins_in,
	output logic [2:0] level_out,
	output logic [2:0] rise_out,
	output logic [2:0] fall_out
);
	logic [2:0] meta_ff; // first stage, read only by the second stage
	logic [2:0] sync_ff; // second stage, safe to use
	logic [2:0] prev_ff; // delayed copy for edge detection

	// synchroniser chain, one loop over the pins
	genvar g;
	generate
		for (g = 0; g < mssis_pkg::NUM_PINS; g++) begin : g_pin
			always_ff @(posedge core_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					meta_ff[g] <= 1'b0;
					sync_ff[g] <= 1'b0;
					prev_ff[g] <= 1'b0;
				end else if (clk_en_in) begin
					meta_ff[g] <= pins_in[g];
					sync_ff[g] <= meta_ff[g];
					prev_ff[g] <= sync_ff[g];
				end
			end
			// one pulse per edge since prev trails sync by exactly one cycle
			assign rise_out[g] = clk_en_in & sync_ff[g] & ~prev_ff[g];
			assign fall_out[g] = clk_en_in & ~sync_ff[g] & prev_ff[g];
		end
	endgenerate
	assign level_out = sync_ff;
endmodule // mssis_sync

// ==== design/mssis_input_stage.sv ====
// file: sensor input detection stage (tacho, encoder, pin assignment)
//
// Design decisions made here: the strobe-only register port without an address and the placing of the registers.
`timescale 1ns/1ps
module mssis_input_stage (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic [2:0] sensor_pins_in,
	input wire logic commutation_event_in, // c event from commutation logic
	input wire logic comparator_disable_bit_in,
	input wire logic sensor_mode_bit_in,
	input wire logic off_input_handling_bit_in,
	input wire logic direct_access_bit_in,
	input wire logic [1:0] tacho_edge_select_in,
	// register port for the input select field
	input wire logic [1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [2:0] reg_rdata_out,
	output logic capture_pulse_out,
	output logic encoder_clk_pulse_out,
	output logic encoder_direction_flag_out,
	output logic speed_mode_out,
	output logic six_step_allow_out,
	output logic comparator_on_out,
	output logic [2:0] analog_pins_out,
	output logic [2:0] digital_pins_out,
	output logic [2:0] gpio_pins_out,
	output logic [2:0] off_ground_out,
	output logic [1:0] input_select_out
);
	logic [2:0] level; // synchronised pin levels
	logic [2:0] rise; // rising edge pulses
	logic [2:0] fall; // falling edge pulses
	logic [1:0] input_select_ff; // active input select
	logic [1:0] preload_ff; // staged value waiting for commutation
	logic preload_pend_ff; // staged value not yet applied
	logic speed_mode; // edge select nonzero
	logic encoder_mode; // speed mode with encoder select
	logic tacho_mode; // speed mode with a tacho pin
	logic sel_rise; // selected tacho pin rise
	logic sel_fall; // selected tacho pin fall
	logic nxt_capture; // next capture pulse
	logic nxt_enc_clk; // next encoder clock pulse
	logic [2:0] sel_onehot; // one-hot of selected pin
	mssis_pkg::mssis_mode_t mode; // decoded stage mode
	logic [2:0] nxt_analog;
	logic [2:0] nxt_digital;
	logic [2:0] nxt_gpio;
	logic [2:0] nxt_ground;
	logic nxt_comp_on;
	logic capture_ff;
	logic enc_clk_ff;
	logic dir_ff;
	logic speed_ff;
	logic six_step_ff;
	logic comp_on_ff;
	logic [2:0] analog_ff;
	logic [2:0] digital_ff;
	logic [2:0] gpio_ff;
	logic [2:0] ground_ff;
	logic [2:0] rdata_ff;

	// pin synchroniser and edge pulse generator
	mssis_sync u_sync (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.clk_en_in(clk_en_in),
		.pins_in(sensor_pins_in),
		.level_out(level),
		.rise_out(rise),
		.fall_out(fall)
	);

	// mode decode
	assign speed_mode = (tacho_edge_select_in != mssis_pkg::TES_OFF);
	// comparator disable with encoder select frees all pins, so no encoder clock then
	assign encoder_mode = speed_mode && (input_select_ff == mssis_pkg::IS_ENCODER)
		&& !comparator_disable_bit_in;
	assign tacho_mode = speed_mode && (input_select_ff != mssis_pkg::IS_ENCODER);

	// input select: direct write, or staged until the next commutation
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			input_select_ff <= mssis_pkg::INPUT_SELECT_RST;
			preload_ff <= mssis_pkg::INPUT_SELECT_RST;
			preload_pend_ff <= 1'b0;
		end else if (clk_en_in) begin
			if (reg_wr_in && direct_access_bit_in) begin
				input_select_ff <= reg_wdata_in;
				preload_ff <= reg_wdata_in;
				preload_pend_ff <= 1'b0;
			end else if (reg_wr_in) begin
				// a write in the commutation cycle waits for the next one
				preload_ff <= reg_wdata_in;
				preload_pend_ff <= 1'b1;
				if (commutation_event_in && preload_pend_ff) begin
					input_select_ff <= preload_ff;
				end
			end else if (commutation_event_in && preload_pend_ff) begin
				input_select_ff <= preload_ff;
				preload_pend_ff <= 1'b0;
			end
		end
	end

	// register read: staged select and direction flag, one cycle later
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_ff <= mssis_pkg::PINS_RST;
		end else if (clk_en_in) begin
			rdata_ff <= reg_rd_in ? {dir_ff, preload_ff} : mssis_pkg::PINS_RST;
		end
	end

	// tacho multiplexer
	always_comb begin
		case (input_select_ff)
			mssis_pkg::IS_PIN_A: sel_onehot = 3'h1;
			mssis_pkg::IS_PIN_B: sel_onehot = 3'h2;
			mssis_pkg::IS_PIN_C: sel_onehot = 3'h4;
			default: sel_onehot = 3'h0;
		endcase
	end
	assign sel_rise = |(rise & sel_onehot);
	assign sel_fall = |(fall & sel_onehot);

	// capture edge choice
	always_comb begin
		case (tacho_edge_select_in)
			mssis_pkg::TES_RISE: nxt_capture = tacho_mode & sel_rise;
			mssis_pkg::TES_FALL: nxt_capture = tacho_mode & sel_fall;
			mssis_pkg::TES_BOTH: nxt_capture = tacho_mode & (sel_rise | sel_fall);
			default: nxt_capture = 1'b0;
		endcase
	end

	// encoder clock: any edge on a or b, so a lone input gives half rate
	assign nxt_enc_clk = encoder_mode &
		(rise[mssis_pkg::PIN_A] | fall[mssis_pkg::PIN_A] |
		rise[mssis_pkg::PIN_B] | fall[mssis_pkg::PIN_B]);

	// event pulse registers
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			capture_ff <= 1'b0;
			enc_clk_ff <= 1'b0;
		end else if (clk_en_in) begin
			capture_ff <= nxt_capture;
			enc_clk_ff <= nxt_enc_clk;
		end else begin
			// a pulse must not stretch across frozen cycles
			capture_ff <= 1'b0;
			enc_clk_ff <= 1'b0;
		end
	end

	// direction: pin a level caught on pin b falling edge, only a flag
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dir_ff <= 1'b0;
		end else if (clk_en_in && encoder_mode && fall[mssis_pkg::PIN_B]) begin
			dir_ff <= level[mssis_pkg::PIN_A];
		end
	end

	// pin assignment mode decode
	always_comb begin
		if (comparator_disable_bit_in && speed_mode && input_select_ff == mssis_pkg::IS_ENCODER)
			mode = mssis_pkg::MSSIS_ALL_GPIO;
		else if (encoder_mode)
			mode = mssis_pkg::MSSIS_ENCODER;
		else if (tacho_mode)
			mode = mssis_pkg::MSSIS_TACHO;
		else if (comparator_disable_bit_in)
			mode = mssis_pkg::MSSIS_COMP_ONLY;
		else if (sensor_mode_bit_in)
			mode = mssis_pkg::MSSIS_POSITION;
		else
			mode = mssis_pkg::MSSIS_SENSORLESS;
	end

	// pin roles per mode
	always_comb begin
		nxt_analog = 3'h0;
		nxt_digital = 3'h0;
		nxt_gpio = 3'h0;
		nxt_ground = 3'h0;
		nxt_comp_on = 1'b0;
		case (mode)
			mssis_pkg::MSSIS_SENSORLESS: begin
				nxt_analog = sel_onehot;
				nxt_comp_on = 1'b1;
				// off pins grounded when the bit is set, else left high impedance
				nxt_ground = off_input_handling_bit_in ? (~sel_onehot & {3{|sel_onehot}}) : 3'h0;
			end
			mssis_pkg::MSSIS_POSITION: begin
				nxt_digital = sel_onehot;
				nxt_gpio = ~sel_onehot & {3{|sel_onehot}};
				nxt_comp_on = 1'b1;
			end
			mssis_pkg::MSSIS_COMP_ONLY: begin
				nxt_analog = sel_onehot;
				nxt_gpio = ~sel_onehot;
				nxt_comp_on = 1'b1;
			end
			mssis_pkg::MSSIS_TACHO: begin
				nxt_digital = sel_onehot;
				nxt_gpio = ~sel_onehot;
				nxt_comp_on = ~comparator_disable_bit_in;
			end
			mssis_pkg::MSSIS_ENCODER: begin
				nxt_digital = 3'h3;
				nxt_gpio = 3'h4;
				nxt_comp_on = 1'b1;
			end
			mssis_pkg::MSSIS_ALL_GPIO: begin
				nxt_gpio = 3'h7;
			end
			default: begin
				nxt_gpio = 3'h7;
			end
		endcase
	end

	// registered pin roles and mode flags
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			analog_ff <= mssis_pkg::PINS_RST;
			digital_ff <= mssis_pkg::PINS_RST;
			gpio_ff <= mssis_pkg::PINS_RST;
			ground_ff <= mssis_pkg::PINS_RST;
			comp_on_ff <= 1'b0;
			speed_ff <= 1'b0;
			six_step_ff <= 1'b0;
		end else if (clk_en_in) begin
			analog_ff <= nxt_analog;
			digital_ff <= nxt_digital;
			gpio_ff <= nxt_gpio;
			ground_ff <= nxt_ground;
			comp_on_ff <= nxt_comp_on;
			speed_ff <= speed_mode;
			six_step_ff <= ~speed_mode;
		end
	end

	assign capture_pulse_out = capture_ff;
	assign encoder_clk_pulse_out = enc_clk_ff;
	assign encoder_direction_flag_out = dir_ff;
	assign speed_mode_out = speed_ff;
	assign six_step_allow_out = six_step_ff;
	assign comparator_on_out = comp_on_ff;
	assign analog_pins_out = analog_ff;
	assign digital_pins_out = digital_ff;
	assign gpio_pins_out = gpio_ff;
	assign off_ground_out = ground_ff;
	assign input_select_out = input_select_ff;
	assign reg_rdata_out = rdata_ff;

	// assertions
	property p_speed_flag;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		clk_en_in |=> (speed_mode_out == $past(speed_mode));
	endproperty
	a_speed_flag: assert property (p_speed_flag) else $error("speed flag wrong");

	property p_no_six_step;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(clk_en_in && speed_mode) |=> !six_step_allow_out;
	endproperty
	a_no_six_step: assert property (p_no_six_step) else $error("six step in speed mode");

	property p_rise_capture;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(clk_en_in && tacho_mode && tacho_edge_select_in == mssis_pkg::TES_RISE && sel_fall)
		|=> !capture_pulse_out;
	endproperty
	a_rise_capture: assert property (p_rise_capture) else $error("capture on fall");

	property p_tacho_capture;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(clk_en_in && tacho_mode && tacho_edge_select_in == mssis_pkg::TES_BOTH
		&& (sel_rise || sel_fall)) |=> capture_pulse_out;
	endproperty
	a_tacho_capture: assert property (p_tacho_capture) else $error("missed capture");

	// first step of both encoder checks: a qualified pin b falling edge
	sequence s_b_fall;
		clk_en_in && encoder_mode && fall[mssis_pkg::PIN_B];
	endsequence

	property p_enc_clk;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s_b_fall |=> encoder_clk_pulse_out;
	endproperty
	a_enc_clk: assert property (p_enc_clk) else $error("missed encoder clock");

	property p_dir;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		s_b_fall |=> (encoder_direction_flag_out == $past(level[mssis_pkg::PIN_A]));
	endproperty
	a_dir: assert property (p_dir) else $error("direction not sampled");

	property p_pulse_single;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		capture_pulse_out |=> !capture_pulse_out;
	endproperty
	a_pulse_single: assert property (p_pulse_single) else $error("capture pulse too long");

	property p_all_gpio;
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(clk_en_in && mode == mssis_pkg::MSSIS_ALL_GPIO)
		|=> (gpio_pins_out == 3'h7 && !comparator_on_out);
	endproperty
	a_all_gpio: assert property (p_all_gpio) else $error("pins not all gpio");
endmodule // mssis_input_stage

// ==== dv/mssis_sensor_model.sv ====
// file: behavioural model of the external speed sensors on the three pins
`timescale 1ns/1ps
module mssis_sensor_model (
	input wire logic core_clk_in,
	output logic [2:0] sensor_pins_out
);
	// sensors drive push-pull levels, so the pins never float
	logic [2:0] pins_ff = 3'h0;
	assign sensor_pins_out = pins_ff;

	// one level change per call, then a quiet cycle so edges stay spaced
	task automatic drive(input logic [2:0] v);
		@(posedge core_clk_in);
		pins_ff <= v;
		@(posedge core_clk_in);
	endtask
endmodule // mssis_sensor_model

// ==== dv/mssis_input_stage_test.sv ====
// file: self-checking bench for the sensor input stage
`timescale 1ns/1ps
module motor_speed_sensor_input_stage_test;
	logic clk = 0, rst_n = 0, cen = 1, comm = 0, comparator_disable_bit = 0, sr = 0, off_input_handling_bit = 0, dac = 1;
	logic wr = 0, rd = 0, rd_d = 0, enc_mode = 0, ed = 0;
	logic [1:0] tes = 2'h0, wdat = 2'h0, isel;
	logic [2:0] pins, rdat, ana, dig, gpo, gnd;
	logic cap, encp, dir, spd, six, cmp;
	int n_fail = 0, checks = 0;
	logic [5:0] pq[$]; // pulse notes: {mask, value} over {capture, enc clock, dir}
	logic [5:0] note; // oldest pulse note under comparison
	logic [2:0] rq[$]; // read notes
	// gray sequence {b, a}; stepping up means pin a leads
	localparam logic [2:0] QUAD [4] = '{3'h0, 3'h1, 3'h3, 3'h2};

	mssis_sensor_model u_model (.core_clk_in(clk), .sensor_pins_out(pins));
	mssis_input_stage u_dut (.core_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(cen),
		.sensor_pins_in(pins), .commutation_event_in(comm), .comparator_disable_bit_in(comparator_disable_bit),
		.sensor_mode_bit_in(sr), .off_input_handling_bit_in(off_input_handling_bit), .direct_access_bit_in(dac),
		.tacho_edge_select_in(tes), .reg_wdata_in(wdat), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdat), .capture_pulse_out(cap), .encoder_clk_pulse_out(encp),
		.encoder_direction_flag_out(dir), .speed_mode_out(spd), .six_step_allow_out(six),
		.comparator_on_out(cmp), .analog_pins_out(ana), .digital_pins_out(dig),
		.gpio_pins_out(gpo), .off_ground_out(gnd), .input_select_out(isel));

	// 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// read data stands only in the cycle after the strobe, zero elsewhere
	always @(posedge clk) rd_d <= rd & cen;
	always @(negedge clk) begin
		if (rd_d && rq.size() > 0) check(rdat, rq.pop_front());
		else check(rdat, 3'h0);
		// encoder select never captures, so only its clock is traced there
		if ((enc_mode ? encp : (cap | encp)) !== 1'b0) begin
			if (pq.size() == 0) check({cap, encp}, 2'h0);
			else begin
				note = pq.pop_front();
				check({cap, encp, dir} & note[5:3], note[2:0]);
			end
		end
	end

	task automatic wr_reg(input logic [1:0] v);
		@(posedge clk);
		wr <= 1;
		wdat <= v;
		@(posedge clk) wr <= 0;
	endtask

	task automatic rd_reg(input logic [2:0] e);
		@(posedge clk);
		rd <= 1;
		rq.push_back(e);
		@(posedge clk) rd <= 0;
	endtask

	// direct access write, as software does at initialisation
	task automatic set_is(input logic [1:0] v);
		@(posedge clk) dac <= 1;
		wr_reg(v);
		@(posedge clk);
		#1 check(isel, v);
	endtask

	task automatic cfg(input logic p, r, d, input logic [1:0] t);
		@(posedge clk);
		comparator_disable_bit <= p;
		sr <= r;
		off_input_handling_bit <= d;
		tes <= t;
	endtask

	// expected {analog, digital, gpio, grounded} masks
	function automatic logic [11:0] roles(input logic p, r, d, input logic [1:0] t, i);
		logic [2:0] s;
		s = 3'h1 << i;
		if (t != 2'h0) return (i == 2'h3) ? (p ? 12'h038 : 12'h0e0) : {3'h0, s, ~s, 3'h0};
		if (p) return {s, 3'h0, ~s, 3'h0};
		if (r) return {3'h0, s, ~s, 3'h0};
		return {s, 6'h0, d ? ~s : 3'h0};
	endfunction

	// random pin activity; only the selected pin may capture
	task automatic tacho(input logic [1:0] t, input logic [1:0] i);
		logic [2:0] v, nv;
		v = 3'h0;
		set_is(i);
		cfg(1'b1, 1'b0, 1'b0, t);
		for (int j = 0; j < 13; j++) begin
			nv = (j == 12) ? 3'h0 : 3'($urandom);
			if ((!v[i] && nv[i] && t[0]) || (v[i] && !nv[i] && t[1])) pq.push_back(6'h34);
			u_model.drive(nv);
			v = nv;
		end
		repeat (6) @(posedge clk);
	endtask

	// quadrature on pins a and b, m masks away a missing channel
	task automatic enc(input logic [1:0] t, input logic fwd, input logic [2:0] m);
		logic [2:0] v, nv;
		logic dk;
		int ph;
		v = 3'h0;
		dk = 0;
		ph = 0;
		set_is(2'h3);
		cfg(1'b0, 1'b0, 1'b0, t);
		enc_mode = 1;
		repeat (16) begin
			ph = fwd ? ph + 1 : ph + 3;
			nv = QUAD[ph % 4] & m;
			if (v[1] && !nv[1]) begin
				ed = nv[0];
				dk = 1;
			end
			if (nv[1:0] != v[1:0]) pq.push_back({2'b01, dk, 2'b01, dk & ed});
			u_model.drive(nv);
			v = nv;
		end
		repeat (6) @(posedge clk);
		enc_mode = 0;
	endtask

	initial begin
		logic p, r, d;
		logic [1:0] t, i;
		void'($urandom(32'h709d7a10));
		repeat (16) @(posedge clk);
		rst_n <= 1;
		// staged select waits for the commutation event
		set_is(2'h1);
		rd_reg(3'h1);
		@(posedge clk) dac <= 0;
		wr_reg(2'h2);
		repeat (2) @(posedge clk);
		#1 check(isel, 2'h1);
		rd_reg(3'h2);
		@(posedge clk) comm <= 1;
		@(posedge clk) comm <= 0;
		@(posedge clk);
		#1 check(isel, 2'h2);
		// a write while the enable is low is lost
		@(posedge clk) cen <= 0;
		dac <= 1;
		wr_reg(2'h3);
		@(posedge clk) cen <= 1;
		@(posedge clk);
		#1 check(isel, 2'h2);
		// pin roles over every documented configuration
		for (int k = 0; k < 128; k++) begin
			{p, r, d, t, i} = k[6:0];
			if (t == 2'h0 && i == 2'h3) continue;
			set_is(i);
			cfg(p, r, d, t);
			repeat (3) @(posedge clk);
			#1 check({ana, dig, gpo, gnd}, roles(p, r, d, t, i));
			check({spd, six}, {t != 2'h0, t == 2'h0});
			check(cmp, !p || t == 2'h0);
		end
		for (int k = 1; k < 4; k++)
			for (int j = 0; j < 3; j++)
				tacho(k[1:0], j[1:0]);
		enc(2'h1, 1'b1, 3'h7);
		enc(2'h2, 1'b0, 3'h7);
		enc(2'h3, 1'b1, 3'h1);
		enc(2'h3, 1'b0, 3'h2);
		rd_reg({ed, 2'h3});
		repeat (4) @(posedge clk);
		check(16'(pq.size() + rq.size()), 16'h0);
		stop_test();
	end

	// the whole run needs well under 10,000 cycles
	initial begin
		#400us;
		n_fail++;
		stop_test();
	end
endmodule // motor_speed_sensor_input_stage_test
